// ==== logic/rsb_map.svh ====
`ifndef RSB_MAP_SVH
`define RSB_MAP_SVH

// Register byte offsets on the AHB-Lite slave.
`define RSB_OFF_SYS_STATUS 8'h00
`define RSB_OFF_DIAG       8'h04
`define RSB_OFF_INT_EN     8'h08
`define RSB_OFF_INT_STAT   8'h0C
`define RSB_OFF_SYS_CFG    8'h10
`define RSB_OFF_PHY_CTRL   8'h14
`define RSB_OFF_SPECIAL    8'h18

// Field widths.
`define RSB_INT_W          8
`define RSB_CAUSE_W        4

// Reset-cause codes allowed after a restart.
`define RSB_CAUSE_POR      4'h0
`define RSB_CAUSE_2        4'h2
`define RSB_CAUSE_C        4'hC
`define RSB_CAUSE_E        4'hE

// Power-on values of the configuration registers.
`define RSB_SYSCFG_POR     9'h020
`define RSB_PHY_POR        12'h404
`define RSB_SPEC_POR       6'h00
`define RSB_DIAG_POR       12'h180
`define RSB_INT_POR        8'h00

`endif

// ==== logic/rsb_pkg.sv ====
`default_nettype none

package rsb_pkg;

   // ------------------------------------------------------------
   // Reset kinds, one-hot, as issued by the mode controller.
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      RSB_K_NONE      = 4'b0000,
      RSB_K_POWER_ON  = 4'b0001,
      RSB_K_STARTUP   = 4'b0010,
      RSB_K_RESTART   = 4'b0100,
      RSB_K_FAILSAFE  = 4'b1000
   } rsb_kind_t;

   // One-cycle reset-kind indication with its wake source and cause.
   typedef struct packed {
      logic       valid;
      rsb_kind_t  kind;
      logic       wake_can;
      logic       wake_lin;
      logic       wake_pin;
      logic [3:0] cause;
   } rsb_rst_req_t;

   // Live status from the transceivers, supplies and sensors.
   typedef struct packed {
      logic       wake_pin_level;
      logic       overtemp;
      logic       debug_mode;
      logic       ground_offset_fault;
      logic [3:0] can_bus_fault_code;
      logic [1:0] lin_bus_fault_code;
      logic       aux_supply_ok;
      logic       can_supply_ok;
      logic       mcu_supply_ok;
      logic [1:0] can_transceiver_state;
   } rsb_live_t;

   // System configuration, bit 0 first from the bottom.
   typedef struct packed {
      logic       limp_output_level;
      logic       limp_output_drive_enable;
      logic       wake_sampling_sel;
      logic       pin_wake_enable;
      logic       mcu_supply_current_monitor_sel;
      logic [1:0] aux_supply_control;
      logic       reset_length_select;
      logic       ground_offset_threshold_sel;
   } rsb_syscfg_t;

   // Physical-layer control.
   typedef struct packed {
      logic lin_transmitter_disable;
      logic lin_wake_enable;
      logic lin_driver_select;
      logic lin_slope_select;
      logic lin_active_request;
      logic can_split_enable;
      logic can_active_request;
      logic can_receiver_select;
      logic can_transmitter_disable;
      logic can_offline_timeout_sel;
      logic can_listen_only_enable;
      logic can_supply_control;
   } rsb_phy_t;

   // Special-mode settings.
   typedef struct packed {
      logic [1:0] mcu_supply_reset_threshold;
      logic [1:0] watchdog_prescale;
      logic       fault_pin_emulation;
      logic       debug_mode_entry_request;
   } rsb_spec_t;

endpackage : rsb_pkg

`default_nettype wire

// ==== logic/rsb_ahb.sv ====
`timescale 1ns/1ps
`default_nettype none

module rsb_ahb (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave side.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Register-file side.
   input  wire logic [31:0] rdata,
   output logic             rd_stb,
   output logic             wr_stb,
   output logic      [7:0]  addr,
   output logic      [31:0] wdata
);

   logic rd_pend_reg;
   logic wr_pend_reg;
   logic hit_reg;
   logic take;

   assign take   = hsel && htrans[1] && hready;
   assign rd_stb = rd_pend_reg && hit_reg;
   assign wr_stb = wr_pend_reg && hit_reg;
   assign wdata  = hwdata;

   // ------------------------------------------------------------
   // Address phase capture.
   // ------------------------------------------------------------
   // Reads take one wait state so that a write in the previous data
   // phase is already stored when the read value is sampled.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
         hit_reg     <= 1'b0;
         addr        <= 8'h00;
      end else begin
         rd_pend_reg <= take && !hwrite;
         wr_pend_reg <= take && hwrite;
         if (take) begin
            hit_reg <= (haddr[31:8] == 24'h000000);
            addr    <= haddr[7:0];
         end
      end
   end

   // Ready, response and read data all leave from flops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
      end else begin
         hresp <= 1'b0;   // Always OKAY.
         if (take && !hwrite) begin
            hreadyout <= 1'b0;
         end else begin
            hreadyout <= 1'b1;
         end
         if (rd_pend_reg) begin
            hrdata <= hit_reg ? rdata : 32'h00000000;
         end
      end
   end

endmodule : rsb_ahb

`default_nettype wire

// ==== logic/rsb_top.sv ====
// Summary of operation
// [R1] Cause code zero at power-on; restart legal codes
// [R2] Start-up keeps history cause, never 1100
// [R3] Power-on clears all three wake flags
// [R4] Start-up sets matching wake flag; restart keeps
// [R5] Enable status zero, or fault status if emulated
// [R6] Diagnosis fixed at power-on, live afterwards
// [R7] Interrupt flags cleared by every reset kind; fail-safe leaves them set here
// [R8] Interrupt enables cleared only at power-on
// [R9] Reset length short at power-on, long later
// [R10] Limp output floats, restart floats it if high, fail-safe drives
// [R11] Listen-only cleared by power-on, fail-safe, CAN wake
// [R12] Physical-layer defaults; supply auto on fail-safe
// [R13] Debug entry, emulation, prescale cleared at power-on
// [R14] Supply threshold cleared at power-on and restart
// [R15] Emulated enable pin high only without CAN fault
// [R16] First-power flag set; overtemp live after power-on
// [R17] Wake level and debug flag always live
// [R18] Reset-kind pulse applies defaults that cycle
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_map.svh"

module rsb_top (
   // Clock and reset.
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // AHB-Lite slave.
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic                 hready,
   input  wire logic [31:0]          hwdata,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   // Mode controller, live status and interrupt events.
   input  wire rsb_pkg::rsb_rst_req_t rst_req,
   input  wire rsb_pkg::rsb_live_t    live,
   input  wire logic [7:0]           int_event,
   // Outputs to the chip.
   output logic                      irq,
   output logic                      enable_pin_status,
   output rsb_pkg::rsb_syscfg_t      syscfg,
   output rsb_pkg::rsb_phy_t         phy,
   output rsb_pkg::rsb_spec_t        spec
);
   import rsb_pkg::*;

   // ------------------------------------------------------------
   // Bus front end.
   // ------------------------------------------------------------
   logic        rd_stb, wr_stb;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;

   rsb_ahb rsb_ahb_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hready, .hwdata, .hrdata, .hreadyout, .hresp, .rdata, .rd_stb,
      .wr_stb, .addr, .wdata);

   // Word select, used by both the read and the write decode.
   function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
      sel = (a[7:2] == off[7:2]);
   endfunction : sel

   function automatic logic cause_legal(input logic [3:0] c);
      cause_legal = (c == `RSB_CAUSE_POR) || (c == `RSB_CAUSE_2) ||
                    (c == `RSB_CAUSE_C) || (c == `RSB_CAUSE_E);
   endfunction : cause_legal

   // ------------------------------------------------------------
   // Reset-kind decode.
   // ------------------------------------------------------------
   logic po, su, rs, fs, any_kind;

   // The pulse acts in its own cycle and outranks software writes.
   assign po = rst_req.valid && (rst_req.kind == RSB_K_POWER_ON); // [R18]
   assign su = rst_req.valid && (rst_req.kind == RSB_K_STARTUP);
   assign rs = rst_req.valid && (rst_req.kind == RSB_K_RESTART);
   assign fs = rst_req.valid && (rst_req.kind == RSB_K_FAILSAFE);
   assign any_kind = po || su || rs;

   // ------------------------------------------------------------
   // System status.
   // ------------------------------------------------------------
   logic [3:0] reset_cause_code_reg;
   logic       can_wake_flag_reg, lin_wake_flag_reg, wake_pin_edge_flag_reg;
   logic       first_power_flag_reg, diag_live_reg;

   // Cause code; an illegal code at restart falls back to zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reset_cause_code_reg <= `RSB_CAUSE_POR;
      end else if (po) begin
         reset_cause_code_reg <= `RSB_CAUSE_POR; // [R1]
      end else if (su) begin
         reset_cause_code_reg <= (rst_req.cause == `RSB_CAUSE_C) ?
                                 `RSB_CAUSE_POR : rst_req.cause; // [R2]
      end else if (rs) begin
         reset_cause_code_reg <= cause_legal(rst_req.cause) ?
                                 rst_req.cause : `RSB_CAUSE_POR; // [R1]
      end
   end

   // Wake flags are set only by the start-up that the wake caused.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         can_wake_flag_reg      <= 1'b0;
         lin_wake_flag_reg      <= 1'b0;
         wake_pin_edge_flag_reg <= 1'b0;
      end else if (po) begin
         can_wake_flag_reg      <= 1'b0; // [R3]
         lin_wake_flag_reg      <= 1'b0;
         wake_pin_edge_flag_reg <= 1'b0;
      end else if (su) begin
         if (rst_req.wake_can) can_wake_flag_reg <= 1'b1; // [R4]
         if (rst_req.wake_lin) lin_wake_flag_reg <= 1'b1;
         if (rst_req.wake_pin) wake_pin_edge_flag_reg <= 1'b1;
      end
   end

   // Power-on marker and the switch from fixed to live diagnosis.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_power_flag_reg <= 1'b1;
         diag_live_reg        <= 1'b0;
      end else if (po) begin
         first_power_flag_reg <= 1'b1; // [R16]
         diag_live_reg        <= 1'b0; // [R6]
      end else if (su || rs) begin
         diag_live_reg        <= 1'b1; // [R6]
      end
   end

   // Enable status follows the CAN fault code only when emulated.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_pin_status <= 1'b0;
      end else if (po) begin
         enable_pin_status <= 1'b0; // [R5]
      end else begin
         enable_pin_status <= diag_live_reg && spec.fault_pin_emulation &&
                              (live.can_bus_fault_code == 4'h0); // [R15]
      end
   end

   // ------------------------------------------------------------
   // Interrupts.
   // ------------------------------------------------------------
   logic [7:0] int_en_reg, int_stat_reg;
   logic       stat_rd;

   assign stat_rd = rd_stb && sel(addr, `RSB_OFF_INT_STAT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_en_reg <= `RSB_INT_POR;
      end else if (po) begin
         int_en_reg <= `RSB_INT_POR; // [R8]
      end else if (wr_stb && sel(addr, `RSB_OFF_INT_EN) && !su && !rs) begin
         int_en_reg <= wdata[7:0];
      end
   end

   // A new event in the read-clear cycle survives the clear.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_stat_reg <= `RSB_INT_POR;
      end else if (any_kind) begin
         int_stat_reg <= `RSB_INT_POR; // [R7]
      end else begin
         int_stat_reg <= (stat_rd ? 8'h00 : int_stat_reg) | int_event;
      end
   end

   // Registered, so irq lags the status by one cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat_reg & int_en_reg);
      end
   end

   // ------------------------------------------------------------
   // Configuration registers.
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         syscfg <= `RSB_SYSCFG_POR;
      end else if (po) begin
         syscfg <= `RSB_SYSCFG_POR; // [R9]
      end else if (fs) begin
         syscfg.reset_length_select      <= 1'b1; // [R9]
         syscfg.limp_output_drive_enable <= 1'b1; // [R10]
         syscfg.limp_output_level        <= 1'b0; // [R10]
      end else if (rs) begin
         syscfg.reset_length_select <= 1'b1; // [R9]
         if (syscfg.limp_output_level) begin
            syscfg.limp_output_drive_enable <= 1'b0; // [R10]
         end
      end else if (wr_stb && sel(addr, `RSB_OFF_SYS_CFG) && !su) begin
         syscfg <= wdata[8:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phy <= `RSB_PHY_POR;
      end else if (po) begin
         phy <= `RSB_PHY_POR; // [R12]
      end else if (fs) begin
         phy.can_supply_control     <= 1'b0; // [R12]
         phy.can_listen_only_enable <= 1'b0; // [R11]
      end else if (su && rst_req.wake_can) begin
         phy.can_listen_only_enable <= 1'b0; // [R11]
      end else if (wr_stb && sel(addr, `RSB_OFF_PHY_CTRL) && !su && !rs) begin
         phy <= wdata[11:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         spec <= `RSB_SPEC_POR;
      end else if (po) begin
         spec <= `RSB_SPEC_POR; // [R13]
      end else if (rs) begin
         spec.mcu_supply_reset_threshold <= 2'b00; // [R14]
      end else if (wr_stb && sel(addr, `RSB_OFF_SPECIAL) && !su) begin
         spec <= wdata[5:0];
      end
   end

   // ------------------------------------------------------------
   // Read mux.
   // ------------------------------------------------------------
   logic [11:0] status_word, diag_word;

   // Live fields are shown as they are; overtemp only after power-on.
   assign status_word = {first_power_flag_reg, enable_pin_status,
                         live.debug_mode,                       // [R17]
                         diag_live_reg && live.overtemp,        // [R16]
                         live.wake_pin_level,                   // [R17]
                         wake_pin_edge_flag_reg, lin_wake_flag_reg,
                         can_wake_flag_reg, reset_cause_code_reg};
   assign diag_word = diag_live_reg ?
                      {live.can_transceiver_state, live.mcu_supply_ok,
                       live.can_supply_ok, live.aux_supply_ok,
                       live.lin_bus_fault_code, live.can_bus_fault_code,
                       live.ground_offset_fault} : `RSB_DIAG_POR; // [R6]

   always_comb begin
      rdata = 32'h00000000;
      if (sel(addr, `RSB_OFF_SYS_STATUS)) rdata = {20'h00000, status_word};
      if (sel(addr, `RSB_OFF_DIAG))       rdata = {20'h00000, diag_word};
      if (sel(addr, `RSB_OFF_INT_EN))     rdata = {24'h000000, int_en_reg};
      if (sel(addr, `RSB_OFF_INT_STAT))   rdata = {24'h000000, int_stat_reg};
      if (sel(addr, `RSB_OFF_SYS_CFG))    rdata = {23'h000000, syscfg};
      if (sel(addr, `RSB_OFF_PHY_CTRL))   rdata = {20'h00000, phy};
      if (sel(addr, `RSB_OFF_SPECIAL))    rdata = {26'h0000000, spec};
   end

   // ------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_cause_po;
      po |=> reset_cause_code_reg == 4'h0;
   endproperty
   a_cause_po: assert property (p_cause_po) // [R1]
      else $error("cause code not zero after power-on");
   property p_cause_su;
      su |=> reset_cause_code_reg != 4'hC;
   endproperty
   a_cause_su: assert property (p_cause_su) // [R2]
      else $error("cause code 1100 after start-up");
   property p_wake_su;
      su && rst_req.wake_can |=> can_wake_flag_reg;
   endproperty
   a_wake_su: assert property (p_wake_su) // [R4]
      else $error("CAN wake flag not set by CAN wake start-up");
   property p_wake_rs;
      rs |=> $stable({can_wake_flag_reg, lin_wake_flag_reg,
                      wake_pin_edge_flag_reg});
   endproperty
   a_wake_rs: assert property (p_wake_rs) // [R4]
      else $error("wake flags changed on restart");
   property p_ens;
      !spec.fault_pin_emulation && !$past(spec.fault_pin_emulation)
         |-> !enable_pin_status;
   endproperty
   a_ens: assert property (p_ens) // [R5]
      else $error("enable status high without emulation");
   property p_en_po;
      po |=> int_en_reg == 8'h00;
   endproperty
   a_en_po: assert property (p_en_po) // [R8]
      else $error("interrupt enables not cleared by power-on");
   property p_int_zero;
      any_kind |=> int_stat_reg == 8'h00 ##1 !irq;
   endproperty
   a_int_zero: assert property (p_int_zero) // [R7]
      else $error("interrupt flags not cleared by reset kind");
   property p_en_keep;
      su || rs |=> $stable(int_en_reg);
   endproperty
   a_en_keep: assert property (p_en_keep) // [R8]
      else $error("interrupt enables changed on start-up or restart");
   property p_rlc;
      rs || fs |=> syscfg.reset_length_select;
   endproperty
   a_rlc: assert property (p_rlc) // [R9]
      else $error("reset length not long after restart or fail-safe");
   property p_limp;
      fs |=> syscfg.limp_output_drive_enable && !syscfg.limp_output_level;
   endproperty
   a_limp: assert property (p_limp) // [R10]
      else $error("limp output not driven low after fail-safe");
   property p_listen;
      fs || (su && rst_req.wake_can) |=> !phy.can_listen_only_enable;
   endproperty
   a_listen: assert property (p_listen) // [R11]
      else $error("listen-only not cleared");
   property p_thr;
      rs |=> spec.mcu_supply_reset_threshold == 2'b00;
   endproperty
   a_thr: assert property (p_thr) // [R14]
      else $error("supply threshold not cleared on restart");

endmodule : rsb_top

`default_nettype wire

// ==== dv/rsb_mcu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Microcontroller side: a single-word AHB-Lite master.
// ------------------------------------------------------------
module rsb_mcu_model (
   // Clock and slave answer.
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // Master request.
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata,
   // Raised when the slave never answers.
   output logic             to_err
);
   // Idle bus from time zero; every transfer is a whole word.
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      to_err = 1'b0;
   end

   // A bounded wait, so a stuck slave ends the run instead of hanging it.
   task automatic wait_rdy();
      int i;
      for (i = 0; i < 64; i++) begin
         @(posedge hclk);
         if (hready === 1'b1) break;
      end
      if (i == 64) to_err <= 1'b1;
   endtask : wait_rdy

   // Address phase held until accepted, then data phase until answered.
   task automatic xfer(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : xfer
endmodule : rsb_mcu_model

`default_nettype wire

// ==== dv/test_reset_state_register_bank.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_reset_state_register_bank;
   import rsb_pkg::*;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic         enable_pin_status, to_err;
   logic  [1:0]  htrans;
   logic  [2:0]  hsize;
   logic  [31:0] haddr, hwdata, hrdata;
   logic  [7:0]  int_event;
   rsb_rst_req_t rst_req;
   rsb_live_t    live;
   rsb_syscfg_t  syscfg;
   rsb_phy_t     phy;
   rsb_spec_t    spec;
   int           n_mismatch = 0;
   int           tests_run = 0;

   rsb_top rsb_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
      .rst_req, .live, .int_event, .irq, .enable_pin_status, .syscfg,
      .phy, .spec);
   rsb_mcu_model rsb_mcu_model_i (.hclk, .hready(hreadyout), .hrdata,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .to_err);

   // 25 MHz clock.
   initial hclk = 1'b0;
   always #20 hclk = ~hclk;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic final_report();
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rdc(input logic [31:0] a, e, input string nm);
      logic [31:0] q;
      rsb_mcu_model_i.xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask : rdc

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      rsb_mcu_model_i.xfer(1'b1, a, d, q);
   endtask : wr

   // One-cycle reset-kind pulse; ports are looked at once it has landed.
   task automatic kick(input rsb_kind_t k, input logic wc, wl, wp,
                       input logic [3:0] c);
      @(posedge hclk);
      rst_req <= rsb_rst_req_t'({1'b1, k, wc, wl, wp, c});
      @(posedge hclk);
      rst_req <= '0;
      #1;
   endtask : kick

   task automatic ev(input logic [7:0] v);
      @(posedge hclk);
      int_event <= v;
      @(posedge hclk);
      int_event <= 8'h00;
      repeat (2) @(posedge hclk);
      #1;
   endtask : ev

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic s_por();
      rdc(32'h00, 32'hA80, "stat");
      rdc(32'h04, 32'h180, "diag");
      rdc(32'h08, 32'h00, "int_en");
      rdc(32'h0C, 32'h00, "int_stat");
      rdc(32'h10, 32'h020, "syscfg");
      rdc(32'h14, 32'h404, "phy");
      rdc(32'h18, 32'h00, "spec");
      wr(32'h1C, 32'hFFFF);
      rdc(32'h1C, 32'h0, "unmapped");
      chk("hresp", 32'h0, hresp);
   endtask : s_por

   // Start-up keeps configuration bar listen-only on a CAN wake, takes its wake source and any cause but 1100.
   task automatic s_startup();
      wr(32'h10, 32'h1FF);
      wr(32'h14, 32'hFFF);
      wr(32'h18, 32'h3F);
      wr(32'h08, 32'hFF);
      kick(RSB_K_STARTUP, 1'b0, 1'b1, 1'b0, 4'hC);
      rdc(32'h00, 32'hBA0, "stat_su");
      rdc(32'h04, 32'hE4B, "diag_su");
      rdc(32'h08, 32'hFF, "int_en_su");
      chk("syscfg_su", 32'h1FF, syscfg);
      chk("spec_su", 32'h3F, spec);
      kick(RSB_K_STARTUP, 1'b1, 1'b0, 1'b0, 4'h2);
      rdc(32'h00, 32'hBB2, "stat_su_can");
      chk("phy_su", 32'hFFD, phy);
   endtask : s_startup

   task automatic s_restart();
      kick(RSB_K_RESTART, 1'b1, 1'b1, 1'b1, 4'hE);
      rdc(32'h00, 32'hBBE, "stat_rs");
      chk("syscfg_rs", 32'h17F, syscfg);
      chk("spec_rs", 32'h0F, spec);
      chk("phy_rs", 32'hFFD, phy);
      rdc(32'h08, 32'hFF, "int_en_rs");
      wr(32'h10, 32'h0FD);
      kick(RSB_K_RESTART, 1'b0, 1'b0, 1'b0, 4'h5);
      rdc(32'h00, 32'hBB0, "stat_rs_bad");
      chk("syscfg_rs2", 32'h0FF, syscfg);
      kick(RSB_K_STARTUP, 1'b0, 1'b0, 1'b1, 4'h2);
      rdc(32'h00, 32'hBF2, "stat_su_pin");
   endtask : s_restart

   task automatic s_failsafe();
      wr(32'h10, 32'h100);
      wr(32'h14, 32'hFFF);
      kick(RSB_K_FAILSAFE, 1'b0, 1'b0, 1'b0, 4'h0);
      chk("syscfg_fs", 32'h082, syscfg);
      chk("phy_fs", 32'hFFC, phy);
   endtask : s_failsafe

   task automatic s_irq();
      wr(32'h08, 32'h01);
      ev(8'h06);
      chk("irq_masked", 32'h0, irq);
      rdc(32'h0C, 32'h06, "int_stat");
      rdc(32'h0C, 32'h00, "int_stat_clr");
      ev(8'h01);
      chk("irq_on", 32'h1, irq);
      rdc(32'h0C, 32'h01, "int_stat1");
      repeat (2) @(posedge hclk);
      #1 chk("irq_off", 32'h0, irq);
      ev(8'h01);
      kick(RSB_K_RESTART, 1'b0, 1'b0, 1'b0, 4'h0);
      rdc(32'h0C, 32'h00, "int_stat_rs");
      rdc(32'h08, 32'h01, "int_en_kept");
   endtask : s_irq

   // Emulated enable pin follows the live CAN fault code.
   task automatic s_ens();
      wr(32'h18, 32'h02);
      @(posedge hclk);
      live.can_bus_fault_code <= 4'h0;
      live.debug_mode <= 1'b0;
      repeat (3) @(posedge hclk);
      #1 chk("ens_ok", 32'h1, enable_pin_status);
      rdc(32'h00, 32'hDF0, "stat_ens");
      @(posedge hclk);
      live.can_bus_fault_code <= 4'h3;
      repeat (3) @(posedge hclk);
      #1 chk("ens_fault", 32'h0, enable_pin_status);
      @(posedge hclk);
      live.can_bus_fault_code <= 4'h0;
      live.debug_mode <= 1'b1;
      wr(32'h18, 32'h00);
      repeat (3) @(posedge hclk);
      #1 chk("ens_off", 32'h0, enable_pin_status);
   endtask : s_ens

   task automatic s_poweron();
      kick(RSB_K_POWER_ON, 1'b0, 1'b0, 1'b0, 4'h0);
      chk("syscfg_po", 32'h020, syscfg);
      chk("phy_po", 32'h404, phy);
      chk("spec_po", 32'h00, spec);
      rdc(32'h00, 32'hA80, "stat_po");
      rdc(32'h04, 32'h180, "diag_po");
      rdc(32'h08, 32'h00, "int_en_po");
   endtask : s_poweron

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   always @(posedge hclk) if (to_err === 1'b1) begin
      n_mismatch++;
      final_report();
   end

   // Live status holds a CAN fault so the emulated pin starts low.
   initial begin
      hresetn = 1'b0;
      rst_req = '0;
      int_event = 8'h00;
      live = rsb_live_t'(15'h7AC7);
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      s_por();
      s_startup();
      s_restart();
      s_failsafe();
      s_irq();
      s_ens();
      s_poweron();
      final_report();
   end
endmodule : test_reset_state_register_bank

`default_nettype wire
